// File: hw/xm_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the transmitter register map
// Assumes: offsets are holding register numbers as seen by the serial host
// Notes:   definitions only
`ifndef XM_DEFINES_SVH
`define XM_DEFINES_SVH
// register numbers
`define XM_OFS_MT_STATUS  16'h0040
`define XM_OFS_DP_STATUS  16'h0041
`define XM_OFS_SP_STATUS  16'h0042
`define XM_OFS_PT_STATUS  16'h0043
`define XM_OFS_CFG_COUNT  16'h0054
`define XM_OFS_DP_SCALED  16'h0074
`define XM_OFS_SP_SCALED  16'h0075
`define XM_OFS_PT_SCALED  16'h0076
`define XM_OFS_XSTAT0     16'h0077
`define XM_OFS_XSTAT1     16'h0078
`define XM_OFS_XSTAT2     16'h0079
`define XM_OFS_MAX_SCALE  16'h007D
`define XM_OFS_SCROLL     16'h007E
`define XM_OFS_DISP_LO    16'h007F
`define XM_OFS_DISP_HI    16'h0080
`define XM_OFS_TURN       16'h0083
`define XM_OFS_FLOAT      16'h0084
`define XM_OFS_BAUD       16'h0085
`define XM_OFS_TMODE      16'h0086
`define XM_OFS_SENSOR     16'h0087
`define XM_OFS_FRAME_ERR  16'h0091
`define XM_OFS_OVERRUN    16'h0093
// status byte fields
`define XM_QUAL_MSB       7
`define XM_QUAL_LSB       6
`define XM_LIM_MSB        5
`define XM_LIM_LSB        4
// writable display item bits
`define XM_DISP_MASK      32'h0007_3FBF
// reset values
`define XM_RST_SCROLL     16'h0003
`define XM_RST_DISP       32'h0000_0001
`define XM_RST_TURN       16'h0000
`define XM_RST_MAX_SCALE  16'h7FFF
`define XM_RST_FLOAT      2'h0
`define XM_RST_BAUD       3'h4
`define XM_RST_SENSOR     1'h0
// value limits
`define XM_FLOAT_MAX      16'h0003
`define XM_BAUD_MIN       16'h0001
`define XM_BAUD_MAX       16'h0005
// timing
`define XM_CLK_HZ         40000000
`define XM_CLK_PERIOD_NS  25
`define XM_MS_NS          1000000
`define XM_SEC_MS         1000
`define XM_BAUD_1         1200
`define XM_BAUD_2         2400
`define XM_BAUD_3         4800
`define XM_BAUD_4         9600
`define XM_BAUD_5         19200
`endif

// File: hw/xm_pkg.sv
// Purpose: shared types of the transmitter register map
// Assumes: nothing
// Notes:   used as xm_pkg::name
package xm_pkg;
   typedef enum logic [1:0] {Q_BAD = 2'b00, Q_POOR = 2'b01, Q_MANUAL = 2'b10, Q_GOOD = 2'b11} quality_type;
   typedef enum logic [1:0] {L_NONE = 2'b00, L_LOW = 2'b01, L_HIGH = 2'b10, L_CONST = 2'b11} limit_type;
   typedef enum logic [1:0] {TM_FIXED = 2'b00, TM_NORMAL = 2'b01, TM_BACKUP = 2'b10} temp_mode_type;
   typedef enum logic {TS_IDLE = 1'b0, TS_WAIT = 1'b1} turn_state_type;
endpackage

// File: hw/meas_status_if.sv
// Purpose: carries one variable's quality and limit state to its status byte encoder
// Assumes: one instance per measured variable
// Notes:   src drives the state, enc returns the byte
`timescale 1ns/1ps
interface meas_status_if;
   xm_pkg::quality_type quality;
   xm_pkg::limit_type   limit;
   logic [7:0]          status;
   modport src (output quality, output limit, input status);
   modport enc (input quality, input limit, output status);
endinterface

// File: hw/status_encoder.sv
// Purpose: packs quality and limit into a variable status byte
// Assumes: quality and limit settle in the same cycle
// Notes:   pure logic; the reader registers the byte
`timescale 1ns/1ps
`include "xm_defines.svh"
module status_encoder (
   meas_status_if.enc port
);
   // quality on top, limit below, low nibble always zero
   always_comb begin
      port.status = 8'h00;
      port.status[`XM_QUAL_MSB:`XM_QUAL_LSB] = port.quality;
      port.status[`XM_LIM_MSB:`XM_LIM_LSB]   = port.limit;
   end
endmodule

// File: hw/event_counter.sv
// Purpose: saturating count of one-cycle error events
// Assumes: events come from logic on i_clk, one pulse per faulty character
// Notes:   holds at all ones so a host never sees a wrapped small value
`timescale 1ns/1ps
module event_counter #(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic         i_event,
   output logic      [W-1:0] o_count
);
   if (W < 1) begin : g_chk
      $error("event_counter width must be positive");
   end

   // saturate instead of wrap
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_count <= '0;
      end else if (i_event && (o_count != {W{1'b1}})) begin
         o_count <= o_count + 1'b1;
      end
   end
endmodule

// File: hw/xm_reg_map.sv
// Purpose: holding register map of the process transmitter as seen by the serial host
// Assumes: the protocol engine presents one read or write strobe per register, on i_clk
// Notes:   answer is a one-cycle ack in the next cycle, with err for refused accesses
`timescale 1ns/1ps
`include "xm_defines.svh"
// Function
// - Status byte quality in bits 7:6: poor 01, manual or fixed 10, good 11.
// - Status byte limit in bits 5:4: none 00, low 01, high 10, constant 11, low nibble zero.
// - Quality bits 00 mean bad, with the same limit encoding.
// - Process temperature status is read-only and shows that variable's live state.
// - Scaled integers of the three variables are read-only at consecutive registers.
// - Display option bits enable single items; only documented bits are kept.
// - Scroll time is read-write and counts seconds between display screens.
// - Turnaround delay is a host-written count of milliseconds before each reply.
// - Float byte order accepts codes 0 to 3 only.
// - Baud codes 1 to 5 give 1200, 2400, 4800, 9600 and 19200 bit/s.
// - Temperature mode codes are fixed 0, normal 1, backup 2.
// - Sensor type code 0 is four-wire, 1 is three-wire resistance sensor.
// - Framing errors of the serial port are counted, read-only.
// - Receive overruns of the serial port are counted, read-only.
module xm_reg_map #(
   parameter int MS_CYCLES = `XM_MS_NS / `XM_CLK_PERIOD_NS,
   parameter int SEC_MS    = `XM_SEC_MS
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_reg_rd,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic             o_reg_ack,
   output logic             o_reg_err,
   output logic      [15:0] o_reg_rdata,
   input  wire logic  [7:0] i_var_quality,
   input  wire logic  [7:0] i_var_limit,
   input  wire logic [15:0] i_dp_scaled,
   input  wire logic [15:0] i_sp_scaled,
   input  wire logic [15:0] i_pt_scaled,
   input  wire logic [47:0] i_xmtr_status,
   input  wire logic        i_frame_err,
   input  wire logic        i_overrun_err,
   input  wire logic        i_reply_req,
   output logic             o_reply_go,
   output logic             o_display_next,
   output logic      [31:0] o_display_items,
   output logic      [15:0] o_max_scale,
   output logic       [1:0] o_float_order,
   output logic      [15:0] o_baud_bit_cycles,
   output logic       [1:0] o_temp_mode,
   output logic             o_sensor_3wire
);
   if (MS_CYCLES < 2 || SEC_MS < 1) begin : g_chk
      $error("xm_reg_map timing parameters too small");
   end

   logic [15:0] scroll_r;
   logic [15:0] turn_r;
   logic  [2:0] baud_r;
   logic [15:0] cfg_count_r;
   logic [15:0] frame_cnt;
   logic [15:0] overrun_cnt;
   logic [31:0] ms_cnt_r;
   logic        ms_tick;
   logic [15:0] sec_ms_r;
   logic [15:0] scroll_cnt_r;
   logic [15:0] turn_cnt_r;
   logic [15:0] rdata_nxt;
   logic        hit;
   logic        wr_ok;
   logic  [7:0] status_byte [4];
   xm_pkg::turn_state_type turn_state_r;

   // accepted value check per writable register; returns 0 for read-only or unmapped
   function automatic logic write_ok(input logic [15:0] a, input logic [15:0] d);
      case (a)
         `XM_OFS_MAX_SCALE, `XM_OFS_SCROLL, `XM_OFS_DISP_LO, `XM_OFS_DISP_HI, `XM_OFS_TURN: write_ok = 1'b1;
         `XM_OFS_FLOAT:  write_ok = (d <= `XM_FLOAT_MAX);
         `XM_OFS_BAUD:   write_ok = (d >= `XM_BAUD_MIN) && (d <= `XM_BAUD_MAX);
         `XM_OFS_TMODE:  write_ok = (d <= 16'(xm_pkg::TM_BACKUP));
         `XM_OFS_SENSOR: write_ok = (d <= 16'h0001);
         default:        write_ok = 1'b0;
      endcase
   endfunction

   // bit period in clocks for a baud code
   function automatic logic [15:0] baud_cycles(input logic [2:0] c);
      case (c)
         3'h1:    baud_cycles = 16'(`XM_CLK_HZ / `XM_BAUD_1);
         3'h2:    baud_cycles = 16'(`XM_CLK_HZ / `XM_BAUD_2);
         3'h3:    baud_cycles = 16'(`XM_CLK_HZ / `XM_BAUD_3);
         3'h4:    baud_cycles = 16'(`XM_CLK_HZ / `XM_BAUD_4);
         default: baud_cycles = 16'(`XM_CLK_HZ / `XM_BAUD_5);
      endcase
   endfunction

   // one encoder per variable: module temp, dp, sp, pt
   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_var
      meas_status_if st ();
      assign st.quality = xm_pkg::quality_type'(i_var_quality[2*gi+:2]);
      assign st.limit   = xm_pkg::limit_type'(i_var_limit[2*gi+:2]);
      assign status_byte[gi] = st.status;
      status_encoder u_enc (
         .port (st)
      );
   end

   event_counter #(.W(16)) u_frame (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_event (i_frame_err),
      .o_count (frame_cnt)
   );

   event_counter #(.W(16)) u_overrun (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_event (i_overrun_err),
      .o_count (overrun_cnt)
   );

   assign wr_ok = i_reg_wr && write_ok(i_reg_addr, i_reg_wdata);

   // read decode; live values are sampled in the strobe cycle
   always_comb begin
      rdata_nxt = 16'h0000;
      hit       = 1'b1;
      case (i_reg_addr)
         `XM_OFS_MT_STATUS: rdata_nxt = {8'h00, status_byte[0]};
         `XM_OFS_DP_STATUS: rdata_nxt = {8'h00, status_byte[1]};
         `XM_OFS_SP_STATUS: rdata_nxt = {8'h00, status_byte[2]};
         `XM_OFS_PT_STATUS: rdata_nxt = {8'h00, status_byte[3]};
         `XM_OFS_CFG_COUNT: rdata_nxt = cfg_count_r;
         `XM_OFS_DP_SCALED: rdata_nxt = i_dp_scaled;
         `XM_OFS_SP_SCALED: rdata_nxt = i_sp_scaled;
         `XM_OFS_PT_SCALED: rdata_nxt = i_pt_scaled;
         `XM_OFS_XSTAT0:    rdata_nxt = i_xmtr_status[47:32];
         `XM_OFS_XSTAT1:    rdata_nxt = i_xmtr_status[31:16];
         `XM_OFS_XSTAT2:    rdata_nxt = i_xmtr_status[15:0];
         `XM_OFS_MAX_SCALE: rdata_nxt = o_max_scale;
         `XM_OFS_SCROLL:    rdata_nxt = scroll_r;
         `XM_OFS_DISP_LO:   rdata_nxt = o_display_items[15:0];
         `XM_OFS_DISP_HI:   rdata_nxt = o_display_items[31:16];
         `XM_OFS_TURN:      rdata_nxt = turn_r;
         `XM_OFS_FLOAT:     rdata_nxt = {14'h0, o_float_order};
         `XM_OFS_BAUD:      rdata_nxt = {13'h0, baud_r};
         `XM_OFS_TMODE:     rdata_nxt = {14'h0, o_temp_mode};
         `XM_OFS_SENSOR:    rdata_nxt = {15'h0, o_sensor_3wire};
         `XM_OFS_FRAME_ERR: rdata_nxt = frame_cnt;
         `XM_OFS_OVERRUN:   rdata_nxt = overrun_cnt;
         default:           hit = 1'b0;
      endcase
   end

   // answer one cycle after the strobe; read-only, unmapped or out-of-range writes are refused
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_reg_ack   <= 1'b0;
         o_reg_err   <= 1'b0;
         o_reg_rdata <= 16'h0000;
      end else begin
         o_reg_ack   <= i_reg_rd || i_reg_wr;
         o_reg_err   <= (i_reg_rd && !hit) || (i_reg_wr && !wr_ok);
         o_reg_rdata <= (i_reg_rd && hit) ? rdata_nxt : 16'h0000;
      end
   end

   // configuration registers; a refused value leaves the old setting in force
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_max_scale     <= `XM_RST_MAX_SCALE;
         scroll_r        <= `XM_RST_SCROLL;
         o_display_items <= `XM_RST_DISP;
         turn_r          <= `XM_RST_TURN;
         o_float_order   <= `XM_RST_FLOAT;
         baud_r          <= `XM_RST_BAUD;
         o_temp_mode     <= xm_pkg::TM_NORMAL;
         o_sensor_3wire  <= `XM_RST_SENSOR;
      end else if (wr_ok) begin
         case (i_reg_addr)
            `XM_OFS_MAX_SCALE: o_max_scale <= i_reg_wdata;
            `XM_OFS_SCROLL:    scroll_r <= i_reg_wdata;
            `XM_OFS_DISP_LO:   o_display_items[15:0] <= i_reg_wdata & 16'(`XM_DISP_MASK);
            `XM_OFS_DISP_HI:   o_display_items[31:16] <= i_reg_wdata & 16'(`XM_DISP_MASK >> 16);
            `XM_OFS_TURN:      turn_r <= i_reg_wdata;
            `XM_OFS_FLOAT:     o_float_order <= i_reg_wdata[1:0];
            `XM_OFS_BAUD:      baud_r <= i_reg_wdata[2:0];
            `XM_OFS_TMODE:     o_temp_mode <= i_reg_wdata[1:0];
            `XM_OFS_SENSOR:    o_sensor_3wire <= i_reg_wdata[0];
            default:           o_max_scale <= o_max_scale;
         endcase
      end
   end

   // change counter wraps; host only needs to see that it moved
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_count_r <= 16'h0000;
      end else if (wr_ok) begin
         cfg_count_r <= cfg_count_r + 16'h0001;
      end
   end

   // bit period follows the baud code
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_baud_bit_cycles <= baud_cycles(`XM_RST_BAUD);
      end else begin
         o_baud_bit_cycles <= baud_cycles(baud_r);
      end
   end

   // free running millisecond prescaler shared by scroll and turnaround
   always_ff @(posedge i_clk) begin
      if (i_srst || ms_tick) begin
         ms_cnt_r <= 32'h0000_0000;
      end else begin
         ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      end
   end
   assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));

   // seconds then screens; a zero scroll time freezes the display
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sec_ms_r       <= 16'h0000;
         scroll_cnt_r   <= 16'h0000;
         o_display_next <= 1'b0;
      end else begin
         o_display_next <= 1'b0;
         if (ms_tick) begin
            if (sec_ms_r == 16'(SEC_MS - 1)) begin
               sec_ms_r <= 16'h0000;
               if (scroll_r != 16'h0000 && scroll_cnt_r >= scroll_r - 16'h0001) begin
                  scroll_cnt_r   <= 16'h0000;
                  o_display_next <= 1'b1;
               end else begin
                  scroll_cnt_r <= scroll_cnt_r + 16'h0001;
               end
            end else begin
               sec_ms_r <= sec_ms_r + 16'h0001;
            end
         end
      end
   end

   // reply holdoff: whole ms ticks after the request, so the wait is turn_r-1 to turn_r ms
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         turn_state_r <= xm_pkg::TS_IDLE;
         turn_cnt_r   <= 16'h0000;
         o_reply_go   <= 1'b0;
      end else begin
         o_reply_go <= 1'b0;
         case (turn_state_r)
            xm_pkg::TS_IDLE: begin
               if (i_reply_req) begin
                  if (turn_r == 16'h0000) begin
                     o_reply_go <= 1'b1;
                  end else begin
                     turn_cnt_r   <= turn_r;
                     turn_state_r <= xm_pkg::TS_WAIT;
                  end
               end
            end
            xm_pkg::TS_WAIT: begin
               if (ms_tick) begin
                  if (turn_cnt_r == 16'h0001) begin
                     o_reply_go   <= 1'b1;
                     turn_state_r <= xm_pkg::TS_IDLE;
                  end
                  turn_cnt_r <= turn_cnt_r - 16'h0001;
               end
            end
            default: turn_state_r <= xm_pkg::TS_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_rd(logic [15:0] a);
      i_reg_rd && !i_reg_wr && i_reg_addr == a;
   endsequence
   sequence s_refused;
      o_reg_ack && o_reg_err;
   endsequence

   a_status_pt_byte: assert property (s_rd(`XM_OFS_PT_STATUS) |=> o_reg_rdata ==
      {8'h00, $past(i_var_quality[7:6]), $past(i_var_limit[7:6]), 4'h0} && !o_reg_err)
      else $error("process temperature status byte wrong");
   a_status_bad_qual: assert property (s_rd(`XM_OFS_MT_STATUS) and i_var_quality[1:0] == 2'b00
      |=> o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[5:4] == $past(i_var_limit[1:0]))
      else $error("bad quality not shown as 00");
   a_status_ro_write: assert property (i_reg_wr && i_reg_addr == `XM_OFS_PT_STATUS |=> s_refused)
      else $error("status write not refused");
   a_scaled_sp_read: assert property (s_rd(`XM_OFS_SP_SCALED) |=> o_reg_rdata == $past(i_sp_scaled))
      else $error("static pressure scaled read wrong");
   a_display_mask_ok: assert property ((o_display_items & ~`XM_DISP_MASK) == 32'h0000_0000)
      else $error("undocumented display bit set");
   a_scroll_nonzero: assert property (o_display_next |-> $past(scroll_r) != 16'h0000 && $past(ms_tick))
      else $error("scroll advance without scroll time");
   a_turn_zero_go: assert property (turn_state_r == xm_pkg::TS_IDLE && i_reply_req && turn_r == 16'h0000
      |=> o_reply_go ##1 !o_reply_go)
      else $error("zero turnaround reply not immediate");
   a_float_code_max: assert property (i_reg_wr && i_reg_addr == `XM_OFS_FLOAT && i_reg_wdata > 16'h0003
      |=> s_refused and $stable(o_float_order))
      else $error("float order code above 3 accepted");
   a_baud_9600_map: assert property (baud_r == 3'h4 ##1 baud_r == 3'h4 |->
      o_baud_bit_cycles == 16'(`XM_CLK_HZ / `XM_BAUD_4))
      else $error("baud 9600 period wrong");
   a_temp_mode_code: assert property (o_temp_mode != 2'b11)
      else $error("illegal temperature mode stored");
   a_sensor_reject: assert property (i_reg_wr && i_reg_addr == `XM_OFS_SENSOR && i_reg_wdata > 16'h0001
      |=> s_refused and $stable(o_sensor_3wire))
      else $error("sensor code above 1 accepted");
   a_frame_count_inc: assert property (i_frame_err && frame_cnt != 16'hFFFF |=> frame_cnt == $past(frame_cnt) + 16'h0001)
      else $error("framing error not counted");
   a_overrun_saturate: assert property (overrun_cnt == 16'hFFFF |=> overrun_cnt == 16'hFFFF)
      else $error("overrun counter wrapped");
   a_cfg_count_inc: assert property (wr_ok |=> cfg_count_r == $past(cfg_count_r) + 16'h0001)
      else $error("config change not counted");
endmodule

// File: testbench/host_engine_model.sv
// Purpose: protocol engine stand-in that issues one register strobe per access
// Assumes: answer comes on the edge that takes the strobe
// Notes:   strobes change 1 ns after a rising edge
`timescale 1ns/1ps
module host_engine_model (
   input  wire logic        i_clk,
   input  wire logic        i_ack,
   input  wire logic        i_err,
   input  wire logic [15:0] i_rdata,
   output logic             o_rd,
   output logic             o_wr,
   output logic      [15:0] o_addr,
   output logic      [15:0] o_wdata
);
   initial begin
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_addr  = 16'h0;
      o_wdata = 16'h0;
   end
   // a missing ack turns the error flag unknown so the caller's compare fails
   task automatic access(input logic wr, input logic [15:0] a, d, output logic e, output logic [15:0] q);
      @(posedge i_clk);
      #1;
      o_rd    = ~wr;
      o_wr    = wr;
      o_addr  = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      e       = i_ack ? i_err : 1'bx;
      q       = i_rdata;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      // idle bus carries inverted values so stale address or data is never mistaken for live
      o_addr  = ~a;
      o_wdata = ~d;
   endtask
endmodule

// File: testbench/test_xm_reg_map.sv
// Purpose: self-checking bench of the transmitter register map
// Assumes: millisecond and second counts shortened by parameters
// Notes:   error saturation run dominates the run time
`timescale 1ns/1ps
module test_xm_reg_map;
   localparam int MS  = 4;
   localparam int SEC = 3;
   localparam logic [15:0] RA [0:11] = '{16'h7D, 16'h7E, 16'h7F, 16'h80, 16'h83, 16'h84, 16'h85, 16'h86,
                                         16'h87, 16'h54, 16'h91, 16'h93};
   localparam logic [15:0] RV [0:11] = '{16'h7FFF, 16'h3, 16'h1, 16'h0, 16'h0, 16'h0, 16'h4, 16'h1,
                                         16'h0, 16'h0, 16'h0, 16'h0};
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        rd, wr, ack, err, go, nxt, s3, e;
   logic [15:0] addr, wdata, rdata, q, maxs, baudc;
   logic [7:0]  qual = 8'h0;
   logic [7:0]  lim = 8'h0;
   logic [15:0] dp = 16'h1234;
   logic [15:0] sp = 16'hA5C3;
   logic [15:0] pt = 16'h8001;
   logic        ferr = 1'b0;
   logic        oerr = 1'b0;
   logic        rreq = 1'b0;
   logic [31:0] disp;
   logic [1:0]  fo, tm;
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;
   int          ncfg = 0;
   int          n;
   always #12.5 clk = ~clk;
   xm_reg_map #(.MS_CYCLES(MS), .SEC_MS(SEC)) i_xm_reg_map (
      .i_clk(clk), .i_srst(srst), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_ack(ack), .o_reg_err(err), .o_reg_rdata(rdata), .i_var_quality(qual), .i_var_limit(lim),
      .i_dp_scaled(dp), .i_sp_scaled(sp), .i_pt_scaled(pt), .i_xmtr_status(48'hC0FFEE123456),
      .i_frame_err(ferr), .i_overrun_err(oerr), .i_reply_req(rreq), .o_reply_go(go), .o_display_next(nxt),
      .o_display_items(disp), .o_max_scale(maxs), .o_float_order(fo), .o_baud_bit_cycles(baudc),
      .o_temp_mode(tm), .o_sensor_3wire(s3));
   host_engine_model i_host_engine_model (.i_clk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
      .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // refused accesses must also return zero data
   task automatic rd_chk(input logic [15:0] a, x, input logic xe);
      i_host_engine_model.access(1'b0, a, 16'h0, e, q);
      chk({31'h0, e}, {31'h0, xe});
      chk({16'h0, q}, {16'h0, xe ? 16'h0 : x});
   endtask
   // accepted writes are tallied for the change counter
   task automatic wr_chk(input logic [15:0] a, d, input logic xe);
      i_host_engine_model.access(1'b1, a, d, e, q);
      chk({31'h0, e}, {31'h0, xe});
      chk({16'h0, q}, 32'h0);
      if (!xe) ncfg++;
   endtask
   // cycles from the taking edge of a reply request to the go pulse
   task automatic turn_chk(input int ms, lo, hi);
      wr_chk(16'h83, ms[15:0], 1'b0);
      rreq = 1'b1;
      @(posedge clk);
      #1;
      rreq = 1'b0;
      n = 1;
      while (go !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   task automatic wait_next;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (nxt !== 1'b1 && n < 200);
   endtask
   task automatic give_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hang guard well above the saturation run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1;
      srst = 1'b0;
      for (int i = 0; i < 12; i++) rd_chk(RA[i], RV[i], 1'b0);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         qual = {i[3:2], 6'h1B};
         lim  = {i[1:0], 6'h24};
         rd_chk(16'h43, {8'h0, i[3:2], i[1:0], 4'h0}, 1'b0);
      end
      // bad quality with high limit on the module temperature byte
      qual = 8'h00;
      lim  = 8'h02;
      rd_chk(16'h40, 16'h0020, 1'b0);
      wr_chk(16'h43, 16'hC0, 1'b1);
      $display("test status done");
      rd_chk(16'h74, 16'h1234, 1'b0);
      rd_chk(16'h75, 16'hA5C3, 1'b0);
      pt = 16'h7FFE;
      rd_chk(16'h76, 16'h7FFE, 1'b0);
      wr_chk(16'h76, 16'h0, 1'b1);
      $display("test scaled done");
      wr_chk(16'h7F, 16'hFFFF, 1'b0);
      wr_chk(16'h80, 16'hFFFF, 1'b0);
      rd_chk(16'h7F, 16'h3FBF, 1'b0);
      rd_chk(16'h80, 16'h0007, 1'b0);
      chk(disp, 32'h00073FBF);
      wr_chk(16'h7D, 16'h1234, 1'b0);
      chk({16'h0, maxs}, 32'h1234);
      $display("test display done");
      for (int v = 0; v < 7; v++) begin
         wr_chk(16'h84, v[15:0], v > 3);
         wr_chk(16'h86, v[15:0], v > 2);
         wr_chk(16'h87, v[15:0], v > 1);
         wr_chk(16'h85, v[15:0], v == 0 || v > 5);
         @(posedge clk);
         #1;
         chk({30'h0, fo}, v > 3 ? 3 : v);
         chk({30'h0, tm}, v > 2 ? 2 : v);
         chk({31'h0, s3}, v > 1 ? 1 : v);
         if (v > 0 && v < 6) chk({16'h0, baudc}, 40000000 / (600 << v));
      end
      rd_chk(16'h85, 16'h5, 1'b0);
      rd_chk(16'h54, ncfg[15:0], 1'b0);
      wr_chk(16'h54, 16'h0, 1'b1);
      rd_chk(16'h92, 16'h0, 1'b1);
      $display("test codes done");
      ferr = 1'b1;
      oerr = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      oerr = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      ferr = 1'b0;
      rd_chk(16'h91, 16'h5, 1'b0);
      rd_chk(16'h93, 16'h3, 1'b0);
      wr_chk(16'h93, 16'h0, 1'b1);
      ferr = 1'b1;
      oerr = 1'b1;
      repeat (65540) @(posedge clk);
      #1;
      ferr = 1'b0;
      oerr = 1'b0;
      rd_chk(16'h91, 16'hFFFF, 1'b0);
      rd_chk(16'h93, 16'hFFFF, 1'b0);
      $display("test counters done");
      turn_chk(0, 1, 1);
      turn_chk(1, 2, MS + 1);
      turn_chk(2, MS + 2, 2 * MS + 1);
      $display("test turnaround done");
      wr_chk(16'h7E, 16'h2, 1'b0);
      wait_next();
      wait_next();
      chk(n, 2 * SEC * MS);
      wr_chk(16'h7E, 16'h0, 1'b0);
      wait_next();
      chk(n, 200);
      $display("test scroll done");
      give_verdict();
   end
endmodule
